// ==== rtl/arm_compare.sv ====
// Threshold compare of one monitor channel.
`timescale 1ns/1ps
`include "arm_params.svh"
module arm_compare
    import arm_pkg::*;
(
    input  wire arm_chan_cfg_t cfg,
    input  wire arm_result_t   result,
    input  wire logic [11:0]   threshold,
    input  wire logic          unit_b,
    output logic               judged,
    output logic               hit
);
    wire sel_ok = unit_b ? (cfg.input_sel <= `ARM_SEL_MAX_B)
                         : (cfg.input_sel <= `ARM_SEL_MAX_A);

    assign judged = cfg.enable && result.valid && (result.unit_b == unit_b)
                    && (result.input_sel == cfg.input_sel) && sel_ok;
    assign hit = cfg.direction ? (result.value < threshold)
                               : (result.value > threshold);
endmodule // arm_compare

// ==== rtl/arm_counter.sv ====
// Match counter of one monitor channel.
`timescale 1ns/1ps
`include "arm_params.svh"
module arm_counter
    import arm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire arm_chan_cfg_t cfg,
    input  wire logic        judged,
    input  wire logic        hit,
    output logic             fire,
    output logic [3:0]       count_q
);
    logic [3:0] count_d;
    wire        at_top = (count_q >= cfg.count);
    wire [3:0]  inc    = at_top ? count_q : 4'(count_q + 4'h1);

    // Consecutive: miss clears; hits climb and saturate at the setting.
    // Cumulative: miss holds; reaching the setting fires and clears.
    always_comb begin
        count_d = count_q;
        fire    = 1'b0;
        if (!cfg.enable) begin
            count_d = 4'h0;
        end else if (judged && hit) begin
            if (cfg.cumulative) begin
                fire    = (4'(count_q + 4'h1) >= cfg.count);
                count_d = fire ? 4'h0 : 4'(count_q + 4'h1);
            end else begin
                count_d = inc;
                fire    = (4'(count_q + 4'h1) >= cfg.count) || at_top;
            end
        end else if (judged && !cfg.cumulative) begin
            count_d = 4'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) count_q <= 4'h0;
        else        count_q <= count_d;
    end
endmodule // arm_counter

// ==== rtl/arm_monitor.sv ====
// Result monitor: thresholds, channel control and monitor interrupts.
`timescale 1ns/1ps
`include "arm_params.svh"
module arm_monitor
    import arm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        repeat_mode,
    input  wire arm_result_t result,
    output logic      [1:0]  mon_irq_a,
    output logic      [1:0]  mon_irq_b
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [11:0]   thr_q [4];
    arm_chan_cfg_t cfg_q [4];
    logic [3:0]    fire;
    logic [3:0]    cnt [4];
    logic [31:0]   rdata_d;
    logic [1:0]    irq_a_d;
    logic [1:0]    irq_b_d;

    function automatic logic [31:0] cfg_word(input arm_chan_cfg_t c,
                                             input logic [3:0] n);
        cfg_word = {16'h0000, n, c.count, c.enable, 1'b0, c.cumulative,
                    c.direction, c.input_sel};
    endfunction

    function automatic logic [7:0] thr_ofs(input int i);
        thr_ofs = 8'(i * 4);
    endfunction

    // ------------------------------------------------------------------
    // Channels: index 0,1 unit A; 2,3 unit B
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic          judged;
            logic          hit;
            arm_chan_cfg_t cfg_eff;
            wire [7:0] ofs_thr = (g == 0) ? `ARM_OFS_A_THR0 :
                                 (g == 1) ? `ARM_OFS_A_THR1 :
                                 (g == 2) ? `ARM_OFS_B_THR0 : `ARM_OFS_B_THR1;
            wire [7:0] ofs_ctl = (g == 0) ? `ARM_OFS_A_CTL0 :
                                 (g == 1) ? `ARM_OFS_A_CTL1 :
                                 (g == 2) ? `ARM_OFS_B_CTL0 : `ARM_OFS_B_CTL1;

            always_comb begin
                cfg_eff        = cfg_q[g];
                cfg_eff.enable = cfg_q[g].enable && repeat_mode;
            end

            // Writes while enabled are taken, but counting is undefined.
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    thr_q[g] <= `ARM_THR_RST;
                    cfg_q[g] <= '0;
                end else if (reg_wr) begin
                    if (reg_addr == ofs_thr)
                        thr_q[g] <= reg_wdata[11:0];
                    if (reg_addr == ofs_ctl) begin
                        cfg_q[g].input_sel  <= reg_wdata[3:0];
                        cfg_q[g].direction  <= reg_wdata[`ARM_CTL_DIR_BIT];
                        cfg_q[g].cumulative <= reg_wdata[`ARM_CTL_MODE_BIT];
                        cfg_q[g].enable     <= reg_wdata[`ARM_CTL_EN_BIT];
                        cfg_q[g].count      <= reg_wdata[11:8];
                    end
                end
            end

            arm_compare u_cmp (
                .cfg       (cfg_eff),
                .result    (result),
                .threshold (thr_q[g]),
                .unit_b    (g >= 2),
                .judged    (judged),
                .hit       (hit)
            );

            arm_counter u_cnt (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .cfg     (cfg_eff),
                .judged  (judged),
                .hit     (hit),
                .fire    (fire[g]),
                .count_q (cnt[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `ARM_OFS_A_THR0: rdata_d = {20'h0_0000, thr_q[0]};
            `ARM_OFS_A_THR1: rdata_d = {20'h0_0000, thr_q[1]};
            `ARM_OFS_B_THR0: rdata_d = {20'h0_0000, thr_q[2]};
            `ARM_OFS_B_THR1: rdata_d = {20'h0_0000, thr_q[3]};
            `ARM_OFS_A_CTL0: rdata_d = cfg_word(cfg_q[0], cnt[0]);
            `ARM_OFS_A_CTL1: rdata_d = cfg_word(cfg_q[1], cnt[1]);
            `ARM_OFS_B_CTL0: rdata_d = cfg_word(cfg_q[2], cnt[2]);
            `ARM_OFS_B_CTL1: rdata_d = cfg_word(cfg_q[3], cnt[3]);
            default:         rdata_d = 32'h0000_0000;
        endcase
        if (!reg_rd) rdata_d = 32'h0000_0000;
    end

    assign irq_a_d = fire[1:0];
    assign irq_b_d = fire[3:2];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
            mon_irq_a <= 2'b00;
            mon_irq_b <= 2'b00;
        end else begin
            reg_rdata <= rdata_d;
            mon_irq_a <= irq_a_d;
            mon_irq_b <= irq_b_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    thr_upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && reg_addr == `ARM_OFS_A_THR0 |=> reg_rdata[31:12] == 20'h0)
        else $error("threshold upper bits not zero");
    thr_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == `ARM_OFS_B_THR1 ##1 !reg_wr ##1 reg_rd
        && reg_addr == `ARM_OFS_B_THR1
        |=> reg_rdata[11:0] == $past(reg_wdata[11:0], 3))
        else $error("threshold readback wrong");
    dir_above_b_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fire[2] && !cfg_q[2].direction |-> result.value > thr_q[2])
        else $error("unit b above match wrong");
    dir_below_b_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fire[3] && cfg_q[3].direction |-> result.value < thr_q[3])
        else $error("unit b below match wrong");
    no_irq_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !repeat_mode |=> mon_irq_a == 2'b00 && mon_irq_b == 2'b00)
        else $error("interrupt outside repeat mode");
    sel_prohib_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_q[0].input_sel > `ARM_SEL_MAX_A |=> !mon_irq_a[0])
        else $error("prohibited selector fired");
    sel_reserved_b_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_q[2].input_sel >= `ARM_SEL_PROHIB_B |=> !mon_irq_b[0])
        else $error("prohibited unit b selector fired");
    dir_above_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fire[0] && !cfg_q[0].direction |-> result.value > thr_q[0])
        else $error("above match wrong");
    dir_below_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fire[1] && cfg_q[1].direction |-> result.value < thr_q[1])
        else $error("below match wrong");
    miss_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        g_ch[0].judged && !g_ch[0].hit && !cfg_q[0].cumulative
        |=> cnt[0] == 4'h0)
        else $error("miss did not clear counter");
    irq_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fire[2] |=> mon_irq_b[0])
        else $error("interrupt not raised");
endmodule // arm_monitor

// ==== rtl/arm_params.svh ====
// Offsets, field positions, reset values and codes of the result monitor.
`ifndef ARM_PARAMS_SVH
`define ARM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ARM_OFS_A_THR0   8'h00
`define ARM_OFS_A_THR1   8'h04
`define ARM_OFS_B_THR0   8'h08
`define ARM_OFS_B_THR1   8'h0C
`define ARM_OFS_A_CTL0   8'h10
`define ARM_OFS_A_CTL1   8'h14
`define ARM_OFS_B_CTL0   8'h18
`define ARM_OFS_B_CTL1   8'h1C
`define ARM_OFS_A_STAT   8'h20
`define ARM_OFS_B_STAT   8'h24

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define ARM_THR_W        12
`define ARM_THR_RST      12'h000
`define ARM_CTL_SEL_LSB  0
`define ARM_CTL_DIR_BIT  4
`define ARM_CTL_MODE_BIT 5
`define ARM_CTL_EN_BIT   7
`define ARM_CTL_CNT_LSB  8
`define ARM_CNT_W        4
`define ARM_SEL_MAX_A    4'h3
`define ARM_SEL_MAX_B    4'hB
`define ARM_SEL_PROHIB_B 4'hC

`endif

// ==== rtl/arm_pkg.sv ====
// Types shared by the result monitor files.
package arm_pkg;

    typedef enum logic [2:0] {
        ARM_IDLE   = 3'b001,
        ARM_ARMED  = 3'b010,
        ARM_REPEAT = 3'b100
    } arm_state_t;

    typedef struct packed {
        logic       valid;
        logic       unit_b;
        logic [3:0] input_sel;
        logic [11:0] value;
    } arm_result_t;

    typedef struct packed {
        logic       enable;
        logic       cumulative;
        logic       direction;
        logic [3:0] input_sel;
        logic [3:0] count;
    } arm_chan_cfg_t;

endpackage

// ==== tb/test_adc_result_monitor_compare.sv ====
// Self-checking testbench of the result monitor thresholds and channels.
`timescale 1ns/1ps
`include "arm_params.svh"
module test_adc_result_monitor_compare
    import arm_pkg::*;
;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        repeat_mode;
    arm_result_t result;
    logic [1:0]  mon_irq_a;
    logic [1:0]  mon_irq_b;
    int          error_cnt;
    int          n_compared;
    logic [31:0] seed;
    logic [11:0] thr [4];
    logic [31:0] ctl [4];
    int          cnt [4];
    logic [3:0]  exp_irq;

    arm_monitor dut (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .repeat_mode (repeat_mode),
        .result      (result),
        .mon_irq_a   (mon_irq_a),
        .mon_irq_b   (mon_irq_b)
    );

    always #25 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(logic [31:0] got, logic [31:0] exp, string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata, exp, "read data");
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Works out the interrupts that one result should raise next cycle.
    task automatic predict(arm_result_t r, logic rm);
        logic h;
        int   need;
        for (int ch = 0; ch < 4; ch++) begin
            exp_irq[ch] = 1'b0;
            // A channel that is off, or out of repeat mode, drops its count.
            if (!rm || !ctl[ch][7])
                cnt[ch] = 0;
            if (r.valid && rm && ctl[ch][7] && r.unit_b == ch[1]
                && r.input_sel == ctl[ch][3:0]) begin
                h = ctl[ch][4] ? (r.value < thr[ch])
                               : (r.value > thr[ch]);
                cnt[ch] = h ? cnt[ch] + 1 : 0;
                need = (ctl[ch][11:8] == 4'h0) ? 1 : int'(ctl[ch][11:8]);
                exp_irq[ch] = h && (cnt[ch] >= need);
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        arm_result_t r;
        logic        rm;
        logic [31:0] d;
        logic [31:0] t;
        clk_sys = 1'b0;
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat_mode = 1'b0;
        result = '0;
        error_cnt = 0;
        n_compared = 0;
        seed = 32'h0000_0EC5;
        exp_irq = 4'h0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd_chk(8'(a * 4), 32'h0000_0000);
        // An unmapped place takes no write and reads back zero.
        wr(8'h30, 32'hFFFF_FFFF);
        rd_chk(8'h30, 32'h0000_0000);
        for (int round = 0; round < 25; round++) begin
            // Channels go quiet before thresholds move, as a change under
            // a live comparison gives no consistent outcome.
            for (int ch = 0; ch < 4; ch++)
                wr(8'(`ARM_OFS_A_CTL0 + ch * 4), 32'h0000_0000);
            for (int ch = 0; ch < 4; ch++) begin
                d = rnd();
                if (round == 0)
                    d = {d[31:12], 12'hFFF};
                thr[ch] = d[11:0];
                wr(8'(ch * 4), d);
                rd_chk(8'(ch * 4), {20'h0_0000, d[11:0]});
            end
            for (int ch = 0; ch < 4; ch++) begin
                t = rnd();
                ctl[ch] = {20'h0_0000, 4'(t[7:0] % 5), t[8] | t[9], 2'b00,
                           t[10], 4'(ch[1] ? t[15:11] % 6 : t[15:11] % 4)};
                cnt[ch] = 0;
                wr(8'(`ARM_OFS_A_CTL0 + ch * 4), ctl[ch]);
            end
            exp_irq = 4'h0;
            for (int k = 0; k <= 60; k++) begin
                t = rnd();
                r = '0;
                r.valid = (k < 60) && (t[1:0] != 2'b00);
                r.unit_b = t[2];
                r.input_sel = {2'b00, t[4:3]};
                r.value = (t[6:5] == 2'b00) ? 12'(thr[t[8:7]] + t[10:9] - 1)
                                            : t[22:11];
                rm = t[25:23] != 3'b000;
                @(posedge clk_sys);
                result <= r;
                repeat_mode <= rm;
                @(negedge clk_sys);
                check({28'h000_0000, mon_irq_b, mon_irq_a}, {28'h000_0000,
                      exp_irq}, "monitor interrupt");
                predict(r, rm);
            end
        end
        stop_test();
    end
endmodule // test_adc_result_monitor_compare
